// file: hdl/tcsf_ctrl.v
// Overview of operation
// - Formatted stop pads zero bytes, ID zero
// - Padding continues until memory-width aligned
// - Every accepted trace byte is written out
// - Hardware FIFO: no padding, but drain all
// - Unformatted stop in circular buffer mode: 0x01 then zero alignment
// - Stop sequence may exceed the minimum
// - Trigger pin or ID 0x7D packet triggers
// - Downstream flush: ack, or full flush in HARDWARE_FIFO_MODE
// - Manual or pin flush flushes upstream sources
// - After a manual, pin or trigger flush (not a downstream one): marker and halt if enabled
// - Circular trigger event: halt, or flush actions
// - Clearing capture enable discards and stops
// - Pending markers go out before flush/stop
// - Scatter-gather uses 4KB pages, linked tables
// - Entry holds address bits 39:12 in 31:4
// - Entry types: last, normal, link
// - Prefetch next entry; wrap after last
// - Bursts start on frame boundaries
// - Stopped only after sequence and, except in software FIFO mode, full drain
`timescale 1ns/10ps
`include "tcsf_defs.vh"
module tcsf_ctrl #(
  parameter AW = 4,
  parameter ALIGN_W = 3,
  parameter PEND_W = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Trace input stream
  input wire trace_valid,
  output wire trace_ready,
  input wire [6:0] trace_id,
  input wire [31:0] trace_data,
  // Pins
  input wire trigger_input,
  input wire flush_input,
  // Upstream flush
  output reg src_flush_req,
  input wire src_flush_ack,
  // Downstream flush request
  input wire down_flush_valid,
  output wire down_flush_ready,
  // Trace output stream
  output wire out_valid,
  input wire out_ready,
  output reg [31:0] out_data,
  output reg [6:0] out_id,
  output reg [39:0] out_addr,
  output wire out_first,
  // Table entry fetch
  output reg tbl_req,
  output reg [39:0] tbl_addr,
  input wire tbl_ack,
  input wire [31:0] tbl_data
);
  localparam S_DIS = 4'b0001;
  localparam S_RUN = 4'b0010;
  localparam S_STPG = 4'b0100;
  localparam S_STPD = 4'b1000;
  localparam DEPTH = 1 << AW;

  function [39:0] ent_addr;
    input [31:0] ent;
    begin
      ent_addr = {ent[31:4], {`TCSF_PAGE_LSB{1'b0}}};
    end
  endfunction

  reg [3:0] state_r;
  reg [31:0] rsz_r;
  reg [31:0] trg_r;
  reg [1:0] mode_r;
  reg [31:0] bus_master_control_r;
  reg [31:0] buffer_base_low_r;
  reg [31:0] buffer_base_high_r;
  reg [`TCSF_FF_W-1:0] formatter_flush_control_r;
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [2:0] s3_r;
  reg [1:0] filt_r;
  reg [1:0] filt_d_r;
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg rd_pend_r;
  reg out_valid_r;
  reg [ALIGN_W-1:0] align_r;
  reg eot_done_r;
  reg [PEND_W-1:0] pend_r;
  reg armed_r;
  reg [31:0] trg_cnt_r;
  reg fl_busy_r;
  reg fl_up_done_r;
  reg fl_down_r;
  reg [31:0] off_r;
  reg [`TCSF_PAGE_OFF_W:0] pg_off_r;
  reg [39:0] cur_page_r;
  reg cur_valid_r;
  reg [39:0] nxt_page_r;
  reg nxt_valid_r;
  reg [3:0] burst_r;

  wire [38:0] ram_rdata;
  wire [39:0] dbase = {buffer_base_high_r[7:0], buffer_base_low_r};
  wire m_cb = mode_r == `TCSF_MODE_CB;
  wire m_swf = mode_r == `TCSF_MODE_SWF;
  wire m_hwf = mode_r == `TCSF_MODE_HWF;
  wire fmt_en = formatter_flush_control_r[`TCSF_FF_FMT_EN];
  wire ti_en = formatter_flush_control_r[`TCSF_FF_TI_EN];
  wire sg_on = bus_master_control_r[`TCSF_AX_SG] & m_cb;
  wire st_run = state_r[1];
  wire st_stpg = state_r[2];
  wire active = st_run | st_stpg;
  wire full = cnt_r == DEPTH[AW:0];
  wire store_idle = (cnt_r == {(AW+1){1'b0}}) & ~out_valid_r & ~rd_pend_r;
  wire wr_ctl = reg_wr & (reg_addr == `TCSF_A_CTL);
  wire cap_clear = wr_ctl & ~reg_wdata[0];
  wire cap_set = wr_ctl & reg_wdata[0];

  // Pin synchronisers: a change counts once stages two and three agree
  wire [1:0] filt_nxt = (s2_r[1:0] == s3_r[1:0]) ? s3_r[1:0] : filt_r;
  wire trig_pin_rise = filt_r[0] & ~filt_d_r[0];
  wire fl_pin_rise = filt_r[1] & ~filt_d_r[1];
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      filt_r <= 2'h0;
      filt_d_r <= 2'h0;
    end else begin
      s1_r <= {1'b0, flush_input, trigger_input};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  // Store writes: markers first, then trace, then the stop sequence
  wire ins_mark = active & (pend_r != {PEND_W{1'b0}}) & ~full;
  assign trace_ready = st_run & ~full & (pend_r == {PEND_W{1'b0}});
  wire trace_take = trace_valid & trace_ready;
  wire seq_slot = st_stpg & (pend_r == {PEND_W{1'b0}}) & ~full & ~fl_busy_r;
  wire put_eot = seq_slot & ~fmt_en & m_cb & ~eot_done_r;
  wire need_pad = (align_r != {ALIGN_W{1'b0}}) & ~m_hwf;
  wire put_pad = seq_slot & ~put_eot & (eot_done_r | fmt_en) & need_pad;
  wire seq_done = st_stpg & (pend_r == {PEND_W{1'b0}}) & ~fl_busy_r & (eot_done_r | fmt_en | ~m_cb) & ~need_pad;
  wire wr_en = ins_mark | trace_take | put_eot | put_pad;
  reg [38:0] wr_word;
  always @* begin
    if (ins_mark) begin
      wr_word = {`TCSF_TRIG_ID, `TCSF_PAD_WORD};
    end else if (trace_take) begin
      wr_word = {trace_id, trace_data};
    end else if (put_eot) begin
      wr_word = {`TCSF_PAD_ID, `TCSF_EOT_WORD};
    end else begin
      wr_word = {`TCSF_PAD_ID, `TCSF_PAD_WORD};
    end
  end

  // Trigger input and trigger event
  wire trig_in = st_run & (trig_pin_rise | (trace_take & (trace_id == `TCSF_TRIG_ID)));
  wire trig_evt = armed_r & (trg_cnt_r == `TCSF_ZERO32) & active;
  wire evt_cb = trig_evt & m_cb;
  wire evt_halt = evt_cb & formatter_flush_control_r[`TCSF_FF_STOPONTRIG];
  wire evt_flush = evt_cb & ~evt_halt & formatter_flush_control_r[`TCSF_FF_FONTRIG];
  wire evt_direct = evt_cb & ~evt_halt & ~evt_flush;

  // Flush sequencing
  wire man_fl = reg_wr & (reg_addr == `TCSF_A_FORMATTER_FLUSH_CONTROL) & reg_wdata[`TCSF_FF_MANFL];
  wire req_fl = man_fl | (formatter_flush_control_r[`TCSF_FF_FLUSH_ON_FLUSH_INPUT] & fl_pin_rise) | evt_flush;
  wire down_fl = down_flush_valid & m_hwf & active;
  wire fl_start = active & ~fl_busy_r & (req_fl | down_fl);
  wire fl_done = fl_busy_r & fl_up_done_r & (pend_r == {PEND_W{1'b0}}) & (~fl_down_r | store_idle);
  wire fl_after = fl_done & ~fl_down_r;
  assign down_flush_ready = down_flush_valid & (~m_hwf | ~active | (fl_done & fl_down_r));

  // Marker bookkeeping
  wire inc_pin = trig_in & ti_en & formatter_flush_control_r[`TCSF_FF_TRIGONPIN];
  wire inc_evt = evt_cb & ti_en & formatter_flush_control_r[`TCSF_FF_TRIGONEVT];
  wire inc_fl = (fl_after | evt_direct) & ti_en & formatter_flush_control_r[`TCSF_FF_TRIGGER_MARKER_ON_FLUSH];
  wire [PEND_W-1:0] pend_nxt = pend_r + {{(PEND_W-1){1'b0}}, inc_pin} + {{(PEND_W-1){1'b0}}, inc_evt} +
    {{(PEND_W-1){1'b0}}, inc_fl} - {{(PEND_W-1){1'b0}}, ins_mark};
  wire stop_req = evt_halt | ((fl_after | evt_direct) & formatter_flush_control_r[`TCSF_FF_HALT_ON_FLUSH_DONE]);

  // Store reads, address generation and the output stage
  wire need_page = ~cur_valid_r | pg_off_r[`TCSF_PAGE_OFF_W];
  wire page_ok = ~sg_on | ~need_page | nxt_valid_r;
  wire out_fire = out_valid & out_ready;
  wire rrd_pop = reg_rd & (reg_addr == `TCSF_A_RRD) & m_swf & out_valid_r;
  // Software FIFO mode stops before the store is empty, so reads must go on once stopped
  wire rd_en = (active | (state_r[3] & m_swf)) & (cnt_r != {(AW+1){1'b0}}) & ~out_valid_r & ~rd_pend_r & page_ok;
  wire [3:0] blen = bus_master_control_r[`TCSF_AX_BL_HI:`TCSF_AX_BL_LO];
  assign out_valid = out_valid_r & ~m_swf;
  assign out_first = burst_r == 4'h0;
  wire stopped_ok = seq_done & (m_swf | store_idle);

  tcsf_store_ram #(
    .W(39),
    .AW(AW)
  ) u_store (
    .ref_clk(ref_clk),
    .wr_en(wr_en),
    .wr_addr(wp_r),
    .wr_data(wr_word),
    .rd_en(rd_en),
    .rd_addr(rp_r),
    .rd_data(ram_rdata)
  );

  // Register writes
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rsz_r <= `TCSF_RSZ_RST;
      trg_r <= `TCSF_ZERO32;
      mode_r <= `TCSF_MODE_CB;
      bus_master_control_r <= `TCSF_ZERO32;
      buffer_base_low_r <= `TCSF_ZERO32;
      buffer_base_high_r <= `TCSF_ZERO32;
      formatter_flush_control_r <= {`TCSF_FF_W{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `TCSF_A_RSZ: rsz_r <= reg_wdata;
        `TCSF_A_TRG: trg_r <= reg_wdata;
        `TCSF_A_MODE: mode_r <= reg_wdata[1:0];
        `TCSF_A_BUS_MASTER_CONTROL: bus_master_control_r <= reg_wdata;
        `TCSF_A_BUFFER_BASE_LOW: buffer_base_low_r <= reg_wdata;
        `TCSF_A_BUFFER_BASE_HIGH: buffer_base_high_r <= reg_wdata;
        `TCSF_A_FORMATTER_FLUSH_CONTROL: formatter_flush_control_r <= reg_wdata[`TCSF_FF_W-1:0] & ~(14'h0001 << `TCSF_FF_MANFL);
        default: ;
      endcase
    end
  end

  // Register reads, data in the following cycle
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= `TCSF_ZERO32;
    end else if (reg_rd) begin
      case (reg_addr)
        `TCSF_A_RSZ: reg_rdata <= rsz_r;
        `TCSF_A_STS: reg_rdata <= {28'h0000000, store_idle, state_r[0] | state_r[3], 2'h0};
        `TCSF_A_RRD: reg_rdata <= (m_swf & out_valid_r) ? out_data : `TCSF_NO_DATA;
        `TCSF_A_TRG: reg_rdata <= trg_r;
        `TCSF_A_CTL: reg_rdata <= {31'h00000000, ~state_r[0]};
        `TCSF_A_MODE: reg_rdata <= {30'h00000000, mode_r};
        `TCSF_A_BUS_MASTER_CONTROL: reg_rdata <= bus_master_control_r;
        `TCSF_A_BUFFER_BASE_LOW: reg_rdata <= buffer_base_low_r;
        `TCSF_A_BUFFER_BASE_HIGH: reg_rdata <= buffer_base_high_r;
        `TCSF_A_FORMATTER_FLUSH_CONTROL: reg_rdata <= {18'h00000, formatter_flush_control_r | ({13'h0000, fl_busy_r} << `TCSF_FF_MANFL)};
        default: reg_rdata <= `TCSF_ZERO32;
      endcase
    end else begin
      reg_rdata <= `TCSF_ZERO32;
    end
  end

  // Capture state machine, store pointers and flush
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= S_DIS;
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      rd_pend_r <= 1'b0;
      out_valid_r <= 1'b0;
      out_data <= `TCSF_ZERO32;
      out_id <= 7'h00;
      align_r <= {ALIGN_W{1'b0}};
      eot_done_r <= 1'b0;
      pend_r <= {PEND_W{1'b0}};
      armed_r <= 1'b0;
      trg_cnt_r <= `TCSF_ZERO32;
      fl_busy_r <= 1'b0;
      fl_up_done_r <= 1'b0;
      fl_down_r <= 1'b0;
      src_flush_req <= 1'b0;
      burst_r <= 4'h0;
    end else if (cap_clear | (state_r[0] & cap_set)) begin
      // Emergency stop discards everything held; a start begins from empty
      state_r <= cap_clear ? S_DIS : S_RUN;
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      rd_pend_r <= 1'b0;
      out_valid_r <= 1'b0;
      align_r <= {ALIGN_W{1'b0}};
      eot_done_r <= 1'b0;
      pend_r <= {PEND_W{1'b0}};
      armed_r <= 1'b0;
      fl_busy_r <= 1'b0;
      fl_up_done_r <= 1'b0;
      fl_down_r <= 1'b0;
      src_flush_req <= 1'b0;
      burst_r <= 4'h0;
    end else begin
      case (state_r)
        S_RUN: if (stop_req) state_r <= S_STPG;
        S_STPG: if (stopped_ok) state_r <= S_STPD;
        S_DIS: state_r <= S_DIS;
        S_STPD: state_r <= S_STPD;
        default: state_r <= S_DIS;
      endcase
      if (wr_en) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
        align_r <= align_r + {{(ALIGN_W-1){1'b0}}, 1'b1};
      end
      if (put_eot) eot_done_r <= 1'b1;
      if (rd_en) rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      cnt_r <= cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
      rd_pend_r <= rd_en;
      if (rd_pend_r) begin
        out_valid_r <= 1'b1;
        out_data <= ram_rdata[31:0];
        out_id <= ram_rdata[38:32];
      end else if (out_fire | rrd_pop) begin
        out_valid_r <= 1'b0;
      end
      if (out_fire) burst_r <= (burst_r + 4'h1 >= blen) ? 4'h0 : burst_r + 4'h1;
      pend_r <= pend_nxt;
      if (trig_in) begin
        armed_r <= 1'b1;
        trg_cnt_r <= trg_r;
      end else if (trig_evt) begin
        armed_r <= 1'b0;
      end else if (armed_r & trace_take) begin
        trg_cnt_r <= trg_cnt_r - 32'h00000001;
      end
      if (fl_start) begin
        fl_busy_r <= 1'b1;
        fl_up_done_r <= 1'b0;
        fl_down_r <= down_fl & ~req_fl;
        src_flush_req <= 1'b1;
      end else if (src_flush_req & src_flush_ack) begin
        src_flush_req <= 1'b0;
        fl_up_done_r <= 1'b1;
      end else if (fl_done) begin
        fl_busy_r <= 1'b0;
        fl_down_r <= 1'b0;
      end
    end
  end

  // Write addressing and scatter-gather table walk
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      off_r <= `TCSF_ZERO32;
      pg_off_r <= {(`TCSF_PAGE_OFF_W+1){1'b0}};
      cur_page_r <= 40'h0000000000;
      cur_valid_r <= 1'b0;
      nxt_page_r <= 40'h0000000000;
      nxt_valid_r <= 1'b0;
      out_addr <= 40'h0000000000;
      tbl_req <= 1'b0;
      tbl_addr <= 40'h0000000000;
    end else if (~active) begin
      off_r <= `TCSF_ZERO32;
      pg_off_r <= {(`TCSF_PAGE_OFF_W+1){1'b0}};
      cur_valid_r <= 1'b0;
      nxt_valid_r <= 1'b0;
      tbl_req <= 1'b0;
      tbl_addr <= dbase;
    end else begin
      if (rd_en & ~sg_on) begin
        out_addr <= dbase + {6'h00, off_r, 2'h0};
        off_r <= (off_r + 32'h00000001 >= rsz_r) ? `TCSF_ZERO32 : off_r + 32'h00000001;
      end else if (rd_en & need_page) begin
        out_addr <= nxt_page_r;
        cur_page_r <= nxt_page_r;
        cur_valid_r <= 1'b1;
        nxt_valid_r <= 1'b0;
        pg_off_r <= {{`TCSF_PAGE_OFF_W{1'b0}}, 1'b1};
      end else if (rd_en) begin
        out_addr <= cur_page_r | {28'h0000000, pg_off_r[`TCSF_PAGE_OFF_W-1:0], 2'h0};
        pg_off_r <= pg_off_r + {{`TCSF_PAGE_OFF_W{1'b0}}, 1'b1};
      end
      if (sg_on & ~nxt_valid_r & ~tbl_req) begin
        tbl_req <= 1'b1;
      end else if (tbl_req & tbl_ack) begin
        tbl_req <= 1'b0;
        case (tbl_data[1:0])
          `TCSF_ENT_LINK: tbl_addr <= ent_addr(tbl_data);
          `TCSF_ENT_NORM: begin
            nxt_page_r <= ent_addr(tbl_data);
            nxt_valid_r <= 1'b1;
            tbl_addr <= tbl_addr + `TCSF_ENT_STEP;
          end
          `TCSF_ENT_LAST: begin
            nxt_page_r <= ent_addr(tbl_data);
            nxt_valid_r <= 1'b1;
            tbl_addr <= dbase;
          end
          default: tbl_addr <= dbase;
        endcase
      end
    end
  end
endmodule // tcsf_ctrl

// file: shared/tcsf_defs.vh
`ifndef TCSF_DEFS_VH
`define TCSF_DEFS_VH

// Register offsets
`define TCSF_A_RSZ 12'h004
`define TCSF_A_STS 12'h00C
`define TCSF_A_RRD 12'h010
`define TCSF_A_TRG 12'h01C
`define TCSF_A_CTL 12'h020
`define TCSF_A_MODE 12'h028
`define TCSF_A_BUS_MASTER_CONTROL 12'h110
`define TCSF_A_BUFFER_BASE_LOW 12'h118
`define TCSF_A_BUFFER_BASE_HIGH 12'h11C
`define TCSF_A_FORMATTER_FLUSH_CONTROL 12'h304

// Reset values
`define TCSF_RSZ_RST 32'h00000080
`define TCSF_ZERO32 32'h00000000

// Formatter and flush control bit positions
`define TCSF_FF_FMT_EN 0
`define TCSF_FF_TI_EN 1
`define TCSF_FF_FLUSH_ON_FLUSH_INPUT 4
`define TCSF_FF_FONTRIG 5
`define TCSF_FF_MANFL 6
`define TCSF_FF_TRIGONPIN 8
`define TCSF_FF_TRIGONEVT 9
`define TCSF_FF_TRIGGER_MARKER_ON_FLUSH 10
`define TCSF_FF_HALT_ON_FLUSH_DONE 12
`define TCSF_FF_STOPONTRIG 13
`define TCSF_FF_W 14

// Status bit positions
`define TCSF_STS_READY 2
`define TCSF_STS_EMPTY 3

// Bus master control fields
`define TCSF_AX_SG 7
`define TCSF_AX_BL_HI 11
`define TCSF_AX_BL_LO 8

// Operating modes
`define TCSF_MODE_CB 2'h0
`define TCSF_MODE_SWF 2'h1
`define TCSF_MODE_HWF 2'h2

// Stream words
`define TCSF_TRIG_ID 7'h7D
`define TCSF_PAD_ID 7'h00
`define TCSF_PAD_WORD 32'h00000000
`define TCSF_EOT_WORD 32'h00000001
`define TCSF_NO_DATA 32'hFFFFFFFF

// Scatter-gather table entries
`define TCSF_ENT_LAST 2'h1
`define TCSF_ENT_NORM 2'h2
`define TCSF_ENT_LINK 2'h3
`define TCSF_PAGE_LSB 12
`define TCSF_PAGE_OFF_W 10
`define TCSF_ENT_STEP 40'h0000000004

`endif

// file: hdl/tcsf_store_ram.v
`timescale 1ns/10ps
module tcsf_store_ram #(
  parameter W = 39,
  parameter AW = 4
) (
  // Clock
  input wire ref_clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  // Read port, data one cycle after the request
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [W-1:0] rd_data
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // tcsf_store_ram

// file: dv/tcsf_ctrl_properties.sv
`timescale 1ns/10ps
`include "tcsf_defs.vh"
module tcsf_ctrl_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register strobe and flush handshakes
  input wire reg_wr,
  input wire src_flush_req,
  input wire src_flush_ack,
  input wire down_flush_valid,
  input wire down_flush_ready,
  // Output stream
  input wire out_valid,
  input wire out_ready,
  input wire [31:0] out_data,
  input wire [6:0] out_id,
  input wire [39:0] out_addr,
  // Table fetch
  input wire tbl_req,
  input wire [39:0] tbl_addr,
  input wire tbl_ack
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // A register write may disable capture, which legally drops anything in flight
  chk_out_hold: assert property (
    out_valid && !out_ready && !reg_wr |=> out_valid && $stable(out_data) && $stable(out_addr) && $stable(out_id))
    else $error("output word changed while stalled");
  chk_out_gap: assert property (
    out_valid && out_ready |=> !(out_valid && out_ready) [*2]) else $error("output words too close");
  chk_marker_zero: assert property (
    out_valid && out_id == `TCSF_TRIG_ID |-> out_data == 32'h00000000) else $error("marker word not zero");
  chk_flush_hold: assert property (
    src_flush_req && !src_flush_ack && !reg_wr |=> src_flush_req) else $error("flush request dropped early");
  chk_tbl_hold: assert property (
    tbl_req && !tbl_ack && !reg_wr |=> tbl_req && $stable(tbl_addr)) else $error("table fetch dropped");
  chk_tbl_align: assert property (
    tbl_req |-> tbl_addr[1:0] == 2'h0) else $error("table address not word aligned");
  chk_out_align: assert property (
    out_valid |-> out_addr[1:0] == 2'h0) else $error("output address not word aligned");
  chk_down_ready: assert property (
    down_flush_ready |-> down_flush_valid) else $error("flush ready without request");
  cover property (out_valid && out_ready && out_id == `TCSF_TRIG_ID);
  cover property (tbl_req && tbl_ack);
  cover property (src_flush_req && src_flush_ack);
endmodule // tcsf_ctrl_chk

bind tcsf_ctrl tcsf_ctrl_chk u_chk (.ref_clk, .rst_b, .reg_wr, .src_flush_req, .src_flush_ack,
  .down_flush_valid, .down_flush_ready, .out_valid, .out_ready, .out_data, .out_id, .out_addr,
  .tbl_req, .tbl_addr, .tbl_ack);

// file: dv/tcsf_far_model.sv
`timescale 1ns/10ps
module tcsf_far_model (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Output sink
  output wire out_ready,
  // Upstream sources
  input wire src_flush_req,
  output reg src_flush_ack = 1'b0,
  // Table memory
  input wire tbl_req,
  input wire [39:0] tbl_addr,
  output reg tbl_ack = 1'b0,
  output reg [31:0] tbl_data = 32'h00000000
);
  reg [3:0] tick_r = 4'h0;
  reg [39:0] fetch_log [0:7];
  integer nfetch = 0;
  integer nflush = 0;
  // Normal page, then a link, then the last page; a normal entry never ends a table
  function [31:0] entry(input [39:0] a);
    case (a)
      40'h0000001000: entry = 32'h00000202;
      40'h0000001004: entry = 32'h00000033;
      default: entry = 32'h00000401;
    endcase
  endfunction
  // Stalls one cycle in eight so the output stage must hold its word
  assign out_ready = (tick_r[2:0] != 3'h5);
  always @(posedge ref_clk) begin
    tick_r <= tick_r + 4'h1;
    tbl_ack <= 1'b0;
    src_flush_ack <= 1'b0;
    // A released data bus keeps changing instead of holding the last entry
    tbl_data <= ~tbl_data;
    if (src_flush_req && !src_flush_ack && tick_r[0] && rst_b) begin
      src_flush_ack <= 1'b1;
      nflush = nflush + 1;
    end
    if (tbl_req && !tbl_ack && tick_r[1] && rst_b) begin
      tbl_ack <= 1'b1;
      tbl_data <= entry(tbl_addr);
      if (nfetch < 8) fetch_log[nfetch] = tbl_addr;
      nfetch = nfetch + 1;
    end
  end
endmodule // tcsf_far_model

// file: dv/tb.sv
`timescale 1ns/10ps
`include "tcsf_defs.vh"
module tb;
  localparam [31:0] FMT = 32'h1 << `TCSF_FF_FMT_EN;
  localparam [31:0] TI = 32'h1 << `TCSF_FF_TI_EN;
  localparam [31:0] FFI = 32'h1 << `TCSF_FF_FLUSH_ON_FLUSH_INPUT;
  localparam [31:0] FTR = 32'h1 << `TCSF_FF_FONTRIG;
  localparam [31:0] FFL = 32'h1 << `TCSF_FF_MANFL;
  localparam [31:0] PIN = 32'h1 << `TCSF_FF_TRIGONPIN;
  localparam [31:0] SFL = 32'h1 << `TCSF_FF_HALT_ON_FLUSH_DONE;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [11:0] reg_addr = 12'h000;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg trace_valid = 1'b0;
  reg [6:0] trace_id = 7'h00;
  reg [31:0] trace_data = 32'h0;
  reg trigger_input = 1'b0;
  reg flush_input = 1'b0;
  reg down_flush_valid = 1'b0;
  wire [31:0] reg_rdata, out_data, tbl_data;
  wire [39:0] out_addr, tbl_addr;
  wire [6:0] out_id;
  wire trace_ready, src_flush_req, src_flush_ack, down_flush_ready, out_valid, out_ready, out_first, tbl_req, tbl_ack;
  integer num_errors = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer i, k, n, m;
  reg [31:0] v;
  reg [31:0] oq_d [$];
  reg [6:0] oq_i [$];
  reg [39:0] oq_a [$];
  reg oq_f [$];
  reg [75:0] rows [0:5];
  tcsf_ctrl u_tcsf_ctrl (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trace_valid,
    .trace_ready, .trace_id, .trace_data, .trigger_input, .flush_input, .src_flush_req, .src_flush_ack,
    .down_flush_valid, .down_flush_ready, .out_valid, .out_ready, .out_data, .out_id, .out_addr, .out_first,
    .tbl_req, .tbl_addr, .tbl_ack, .tbl_data);
  tcsf_far_model u_tcsf_far_model (.ref_clk, .rst_b, .out_ready, .src_flush_req, .src_flush_ack,
    .tbl_req, .tbl_addr, .tbl_ack, .tbl_data);
  initial forever #12.5 ref_clk = ~ref_clk;
  task report_and_stop;
    begin
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      oq_d.push_back(out_data);
      oq_i.push_back(out_id);
      oq_a.push_back(out_addr);
      oq_f.push_back(out_first);
    end
  end
  task chk(input [63:0] s, input [63:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: saw %0h, expected %0h", $time, s, e);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [11:0] a, output [31:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      d = reg_rdata;
    end
  endtask
  // Bounded, so a word refused after a stop cannot hang the run
  task send(input [6:0] id, input [31:0] d);
    integer j;
    begin
      trace_id <= id;
      trace_data <= d;
      trace_valid <= 1'b1;
      j = 0;
      do begin
        @(posedge ref_clk);
        j = j + 1;
      end while (trace_ready !== 1'b1 && j < 100);
      trace_valid <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task pin_pulse(input sel);
    begin
      if (sel) trigger_input <= 1'b1;
      else flush_input <= 1'b1;
      repeat (6) @(posedge ref_clk);
      trigger_input <= 1'b0;
      flush_input <= 1'b0;
    end
  endtask
  task wait_stop;
    integer j;
    begin
      v = 32'h0;
      for (j = 0; j < 300 && v[`TCSF_STS_READY] !== 1'b1; j = j + 1) rd(`TCSF_A_STS, v);
      chk(v[`TCSF_STS_READY], 1'b1);
    end
  endtask
  task sess(input [1:0] md, input [31:0] f, input [31:0] t, input integer cnt);
    integer j;
    begin
      wr(`TCSF_A_CTL, 32'h0);
      wr(`TCSF_A_MODE, {30'h0, md});
      wr(`TCSF_A_FORMATTER_FLUSH_CONTROL, f);
      wr(`TCSF_A_TRG, t);
      oq_d.delete();
      oq_i.delete();
      oq_a.delete();
      oq_f.delete();
      wr(`TCSF_A_CTL, 32'h1);
      for (j = 0; j < cnt; j = j + 1) send(7'h05, 32'hA0 + j);
    end
  endtask
  // Data words, then padding: 0x01 first when unformatted, zero words after
  task chk_stream(input integer cnt, input eot, input pad, input integer step, input [39:0] base);
    integer j;
    begin
      if (pad) chk(oq_d.size() % 8, 0);
      else chk(oq_d.size(), cnt);
      chk(oq_d.size() >= cnt, 1);
      for (j = 0; j < oq_d.size(); j = j + 1) begin
        chk(oq_d[j], j < cnt ? 32'hA0 + j : (eot && j == cnt) ? 32'h1 : 32'h0);
        chk(oq_i[j], j < cnt ? 7'h05 : `TCSF_PAD_ID);
        chk(oq_f[j], 1'b1);
        if (step >= 0) chk(oq_a[j], base + step * j);
      end
    end
  endtask
  initial begin
    rows[0] = {`TCSF_A_RSZ, `TCSF_RSZ_RST, 32'h00000080};
    rows[1] = {`TCSF_A_STS, 32'h0000000C, 32'h0000000C};
    rows[2] = {`TCSF_A_TRG, 32'h00000000, 32'h00000055};
    rows[3] = {`TCSF_A_BUS_MASTER_CONTROL, 32'h00000000, 32'h00000100};
    rows[4] = {`TCSF_A_BUFFER_BASE_HIGH, 32'h00000000, 32'h00000100};
    rows[5] = {12'h200, 32'h00000000, 32'h00000000};
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 6; i = i + 1) begin
      rd(rows[i][75:64], v);
      chk(v, rows[i][63:32]);
      wr(rows[i][75:64], rows[i][31:0]);
      rd(rows[i][75:64], v);
      chk(v, rows[i][31:0]);
    end
    wr(`TCSF_A_BUFFER_BASE_LOW, 32'h100);
    sess(`TCSF_MODE_CB, FMT | TI | SFL | FFI, 0, 3);
    pin_pulse(1'b0);
    wait_stop;
    chk_stream(3, 0, 1, 4, 40'h100);
    wr(`TCSF_A_RSZ, 32'h1);
    sess(`TCSF_MODE_CB, SFL, 0, 5);
    wr(`TCSF_A_FORMATTER_FLUSH_CONTROL, SFL | FFL);
    wait_stop;
    chk_stream(5, 1, 1, 0, 40'h100);
    wr(`TCSF_A_RSZ, 32'h80);
    wr(`TCSF_A_BUS_MASTER_CONTROL, 32'h80);
    wr(`TCSF_A_BUFFER_BASE_LOW, 32'h1000);
    sess(`TCSF_MODE_CB, FMT | SFL, 0, 1);
    wr(`TCSF_A_FORMATTER_FLUSH_CONTROL, FMT | SFL | FFL);
    wait_stop;
    chk(oq_a[0], 40'h20000);
    chk(u_tcsf_far_model.fetch_log[0], 40'h1000);
    chk(u_tcsf_far_model.fetch_log[1], 40'h1004);
    wr(`TCSF_A_BUS_MASTER_CONTROL, 32'h0);
    sess(`TCSF_MODE_SWF, FMT | TI | SFL, 0, 2);
    wr(`TCSF_A_FORMATTER_FLUSH_CONTROL, FMT | TI | SFL | FFL);
    k = 0;
    for (i = 0; i < 60; i = i + 1) begin
      rd(`TCSF_A_RRD, v);
      if (v !== `TCSF_NO_DATA) begin
        chk(v, k < 2 ? 32'hA0 + k : 32'h0);
        k = k + 1;
      end
    end
    chk(k % 8, 0);
    wait_stop;
    for (m = 0; m < 2; m = m + 1) begin
      sess(`TCSF_MODE_CB, FMT | TI | PIN | FTR | SFL, 2, 0);
      n = u_tcsf_far_model.nflush;
      if (m == 0) pin_pulse(1'b1);
      else send(`TCSF_TRIG_ID, 32'h0);
      send(7'h05, 32'hA0);
      send(7'h05, 32'hA1);
      wait_stop;
      k = 0;
      for (i = 0; i < oq_i.size(); i = i + 1) if (oq_i[i] === `TCSF_TRIG_ID) k = k + 1;
      chk(k > 0, 1);
      chk(u_tcsf_far_model.nflush > n, 1);
    end
    sess(`TCSF_MODE_CB, FMT, 0, 4);
    wr(`TCSF_A_CTL, 32'h0);
    rd(`TCSF_A_STS, v);
    chk(v[`TCSF_STS_READY], 1'b1);
    n = oq_d.size();
    repeat (20) @(posedge ref_clk);
    chk(oq_d.size(), n);
    sess(`TCSF_MODE_CB, FMT | TI, 0, 1);
    down_flush_valid <= 1'b1;
    @(posedge ref_clk);
    chk(down_flush_ready, 1'b1);
    down_flush_valid <= 1'b0;
    sess(`TCSF_MODE_HWF, FMT | TI | SFL, 0, 2);
    n = u_tcsf_far_model.nflush;
    down_flush_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i = i + 1;
    end while (down_flush_ready !== 1'b1 && i < 200);
    down_flush_valid <= 1'b0;
    chk(i > 1 && i < 200, 1);
    chk(u_tcsf_far_model.nflush > n, 1);
    wr(`TCSF_A_FORMATTER_FLUSH_CONTROL, FMT | TI | SFL | FFL);
    wait_stop;
    chk_stream(2, 0, 0, -1, 40'h0);
    report_and_stop;
  end
endmodule // tb
